// File: design/debounced_key_port_wakeup.sv
// two debounced key ports with wake-up flags and an external wake pin
// assumes a classic wishbone master on the core clock and pins outside it
// What this block does
// - debounce interval chosen by software among three pre-divider taps, 32/8/2 ms.
// - after reset the slowest 32 ms tap is selected.
// - pins set as outputs take no part in debounce detection.
// - detection needs a one-pin change while the other pins stay low.
// - a port A change seen on two successive taps sets the port A wake flag.
// - a set wake flag stops that port's debounce clock until cleared.
// - the wake condition write clears the flag and restarts the clock.
// - a set wake flag raises halt request 0; irq when enabled.
// - port B debounces the same way with its own wake flag.
// - port B resets to input, each bit settable as input or output.
// - output writes reach only pins set as outputs.
// - input reads give pins for inputs and latches for outputs.
// - each port B pin has a pull-low enabled by the setup write.
// - a port B pin set as output has its pull-low forced off.
// - port B pins double as segment outputs, chosen by a build option.
// - the selected edge on the external pin sets halt request 2.
// - with its halt enable set, the pin sets start flag 2 and wakes.
// - the external pin interrupts only while its irq enable is set.
// - port A resets to input, each bit settable as input or output.
// - tap intervals assume a 32768 Hz pre-divider source.
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
module debounced_key_port_wakeup #(
	parameter bit          PORT_B_IS_IO       = 1'b1, // build option
	parameter bit          EXT_RISING_EDGE    = 1'b1, // build option
	parameter int unsigned PREDIV_TICK_CYCLES = key_port_pkg::PREDIV_TICK_CYCLES
) (
	input  wire logic        i_core_clk,              // 10 MHz core clock
	input  wire logic        i_reset,                 // synchronous reset
	input  wire logic        i_wb_cyc,                // wishbone cycle
	input  wire logic        i_wb_stb,                // wishbone strobe
	input  wire logic        i_wb_we,                 // wishbone write
	input  wire logic [7:0]  i_wb_adr,                // wishbone byte address
	input  wire logic [3:0]  i_wb_sel,                // wishbone byte select
	input  wire logic [31:0] i_wb_dat,                // wishbone write data
	output logic      [31:0] o_wb_dat,                // wishbone read data
	output logic             o_wb_ack,                // wishbone ack
	input  wire logic [3:0]  i_key_port_a,            // port A pin levels
	output logic      [3:0]  o_key_port_a,            // port A drive value
	output logic      [3:0]  o_key_port_a_oe,         // port A drive enable
	output logic      [3:0]  o_key_port_a_pull,       // port A pull-low on
	input  wire logic [3:0]  i_key_port_b,            // port B pin levels
	input  wire logic [3:0]  i_shared_segment_output, // segment data for B pins
	output logic      [3:0]  o_key_port_b,            // port B drive value
	output logic      [3:0]  o_key_port_b_oe,         // port B drive enable
	output logic      [3:0]  o_key_port_b_pull,       // port B pull-low on
	input  wire logic        i_ext_pin,               // external wake pin
	output logic             o_port_halt_release_req, // halt request 0
	output logic             o_port_irq,              // port interrupt request
	output logic             o_ext_irq,               // ext pin interrupt request
	output logic             o_wake                   // halt release signal
);
	// port input read: latch for outputs, pin for inputs
	function automatic logic [3:0] port_read(input logic [3:0] dir,
		input logic [3:0] latch, input logic [3:0] pins);
		port_read = (dir & latch) | (~dir & pins);
	endfunction

	// tap pulse when the low stages of the pre-divider wrap
	function automatic logic tap_pulse(input logic tick,
		input logic [key_port_pkg::PREDIV_WIDTH-1:0] ph,
		input int unsigned stage);
		logic [key_port_pkg::PREDIV_WIDTH-1:0] low_mask;
		low_mask  = (key_port_pkg::PREDIV_WIDTH)'((1 << stage) - 1);
		tap_pulse = tick && ((ph & low_mask) == low_mask);
	endfunction

	key_port_pkg::tap_sel_type tap_sel;

	logic [8:0]  tick_count;
	logic        prediv_tick;
	logic [key_port_pkg::PREDIV_WIDTH-1:0] prediv;
	logic        tap_now;

	logic [7:0]  setup_a;
	logic [7:0]  setup_b;
	logic [3:0]  latch_a;
	logic [3:0]  latch_b;
	logic [7:0]  wake_mask;
	logic [2:0]  enables;

	logic        port_a_wake_flag;
	logic        port_b_wake_flag;
	logic        ext_pin_halt_release_req;
	logic        ext_start_flag;

	logic [3:0]  pins_a;
	logic [3:0]  pins_b;
	logic        ext_level;
	logic        ext_level_q;
	logic        ext_edge;

	logic        detect_a;
	logic        detect_b;
	logic        wake_cond_write;
	logic        bus_req;
	logic        wr_en;
	logic [7:0]  wdata;
	logic [7:0]  next_rdata;
	logic [3:0]  dir_a;
	logic [3:0]  dir_b;

	assign bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign wr_en   = bus_req && i_wb_we && i_wb_sel[0];
	assign wdata   = i_wb_dat[7:0];
	assign dir_a   = setup_a[3:0];
	assign dir_b   = PORT_B_IS_IO ? setup_b[3:0] : 4'h0;

	assign wake_cond_write = wr_en && (i_wb_adr == key_port_pkg::REG_WAKE_COND);

	pin_sync #(
		.WIDTH (4)
	) u_sync_a (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_pin      (i_key_port_a),
		.o_level    (pins_a)
	);

	pin_sync #(
		.WIDTH (4)
	) u_sync_b (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_pin      (i_key_port_b),
		.o_level    (pins_b)
	);

	pin_sync #(
		.WIDTH (1)
	) u_sync_ext (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_pin      (i_ext_pin),
		.o_level    (ext_level)
	);

	// pre-divider: one tick per 32768 Hz period, then binary stages
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			tick_count  <= 9'h000;
			prediv_tick <= 1'b0;
			prediv      <= '0;
		end
		else
		begin
			prediv_tick <= 1'b0;
			if (tick_count == 9'(PREDIV_TICK_CYCLES - 1))
			begin
				tick_count  <= 9'h000;
				prediv_tick <= 1'b1;
			end
			else
				tick_count <= tick_count + 9'h001;
			if (prediv_tick)
				prediv <= prediv + 1'b1;
		end
	end

	always_comb
	begin
		case (tap_sel)
			key_port_pkg::TAP_SLOW:
				tap_now = tap_pulse(prediv_tick, prediv, key_port_pkg::TAP_SLOW_STAGE);
			key_port_pkg::TAP_MID:
				tap_now = tap_pulse(prediv_tick, prediv, key_port_pkg::TAP_MID_STAGE);
			key_port_pkg::TAP_FAST:
				tap_now = tap_pulse(prediv_tick, prediv, key_port_pkg::TAP_FAST_STAGE);
			default:
				tap_now = tap_pulse(prediv_tick, prediv, key_port_pkg::TAP_SLOW_STAGE);
		endcase
	end

	// debounce clocks stop while a port's flag is held
	key_debounce u_debounce_a (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_tick     (tap_now && !port_a_wake_flag),
		.i_restart  (wake_cond_write),
		.i_pins     (pins_a),
		.i_watch    (~dir_a & wake_mask[3:0]),
		.o_detect   (detect_a)
	);

	key_debounce u_debounce_b (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_tick     (tap_now && !port_b_wake_flag && PORT_B_IS_IO),
		.i_restart  (wake_cond_write),
		.i_pins     (pins_b),
		.i_watch    (~dir_b & wake_mask[7:4]),
		.o_detect   (detect_b)
	);

	// debounce tap selection
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
			tap_sel <= key_port_pkg::TAP_RESET;
		else if (wr_en && i_wb_adr == key_port_pkg::REG_CLOCK_SELECT)
		begin
			case (wdata[1:0])
				2'h1:    tap_sel <= key_port_pkg::TAP_MID;
				2'h2:    tap_sel <= key_port_pkg::TAP_FAST;
				default: tap_sel <= key_port_pkg::TAP_SLOW;
			endcase
		end
	end

	// wake condition: pin selection; the write itself clears the flags
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
			wake_mask <= key_port_pkg::WAKE_MASK_RESET;
		else if (wake_cond_write)
			wake_mask <= wdata;
	end

	// set wins over the clear in the same cycle
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			port_a_wake_flag <= 1'b0;
			port_b_wake_flag <= 1'b0;
		end
		else
		begin
			port_a_wake_flag <= detect_a || (port_a_wake_flag && !wake_cond_write);
			port_b_wake_flag <= detect_b || (port_b_wake_flag && !wake_cond_write);
		end
	end

	// enables for the port interrupt and the external pin
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
			enables <= key_port_pkg::ENABLES_RESET;
		else if (wr_en && i_wb_adr == key_port_pkg::REG_ENABLES)
			enables <= wdata[2:0];
	end

	// external pin: edge polarity fixed by build option
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
			ext_level_q <= 1'b0;
		else
			ext_level_q <= ext_level;
	end

	assign ext_edge = EXT_RISING_EDGE ? (ext_level && !ext_level_q)
	                                  : (!ext_level && ext_level_q);

	// status write of 1 clears the external request and start flag
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			ext_pin_halt_release_req <= 1'b0;
			ext_start_flag           <= 1'b0;
		end
		else
		begin
			ext_pin_halt_release_req <= ext_edge || (ext_pin_halt_release_req
				&& !(wr_en && i_wb_adr == key_port_pkg::REG_STATUS
				&& wdata[key_port_pkg::ST_EXT_HRQ]));
			ext_start_flag <= (ext_edge && enables[key_port_pkg::EN_EXT_HALT])
				|| (ext_start_flag && !(wr_en && i_wb_adr == key_port_pkg::REG_STATUS
				&& wdata[key_port_pkg::ST_EXT_START]));
		end
	end

	// request and wake outputs
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			o_port_halt_release_req <= 1'b0;
			o_port_irq              <= 1'b0;
			o_ext_irq               <= 1'b0;
			o_wake                  <= 1'b0;
		end
		else
		begin
			o_port_halt_release_req <= port_a_wake_flag || port_b_wake_flag;
			o_port_irq <= (port_a_wake_flag || port_b_wake_flag)
				&& enables[key_port_pkg::EN_PORT_IRQ];
			o_ext_irq <= ext_pin_halt_release_req
				&& enables[key_port_pkg::EN_EXT_IRQ];
			o_wake <= port_a_wake_flag || port_b_wake_flag || ext_start_flag;
		end
	end

	// port setup and output latches; setup holds direction and pull-low
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			setup_a <= key_port_pkg::SETUP_RESET;
			setup_b <= key_port_pkg::SETUP_RESET;
			latch_a <= key_port_pkg::LATCH_RESET;
			latch_b <= key_port_pkg::LATCH_RESET;
		end
		else if (wr_en)
		begin
			case (i_wb_adr)
				key_port_pkg::REG_PORT_A_SETUP: setup_a <= wdata;
				key_port_pkg::REG_PORT_A_OUT:   latch_a <= wdata[3:0];
				key_port_pkg::REG_PORT_B_SETUP: setup_b <= wdata;
				key_port_pkg::REG_PORT_B_OUT:   latch_b <= wdata[3:0];
				default:                        latch_a <= latch_a;
			endcase
		end
	end

	// pins: latch reaches a pin only when that bit is output
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			o_key_port_a      <= 4'h0;
			o_key_port_a_oe   <= 4'h0;
			o_key_port_a_pull <= 4'h0;
			o_key_port_b      <= 4'h0;
			o_key_port_b_oe   <= 4'h0;
			o_key_port_b_pull <= 4'h0;
		end
		else
		begin
			o_key_port_a      <= latch_a & dir_a;
			o_key_port_a_oe   <= dir_a;
			o_key_port_a_pull <= setup_a[7:4] & ~dir_a;
			if (PORT_B_IS_IO)
			begin
				o_key_port_b      <= latch_b & dir_b;
				o_key_port_b_oe   <= dir_b;
				o_key_port_b_pull <= setup_b[7:4] & ~dir_b;
			end
			else
			begin
				o_key_port_b      <= i_shared_segment_output;
				o_key_port_b_oe   <= 4'hF;
				o_key_port_b_pull <= 4'h0;
			end
		end
	end

	// read mux; unmapped addresses read zero
	always_comb
	begin
		case (i_wb_adr)
			key_port_pkg::REG_CLOCK_SELECT: next_rdata = {6'h00, tap_sel};
			key_port_pkg::REG_WAKE_COND:    next_rdata = wake_mask;
			key_port_pkg::REG_ENABLES:      next_rdata = {5'h00, enables};
			key_port_pkg::REG_STATUS:       next_rdata = {3'h0, ext_start_flag,
				ext_pin_halt_release_req, o_port_halt_release_req,
				port_b_wake_flag, port_a_wake_flag};
			key_port_pkg::REG_PORT_A_SETUP: next_rdata = setup_a;
			key_port_pkg::REG_PORT_A_OUT:   next_rdata = {4'h0, latch_a};
			key_port_pkg::REG_PORT_A_IN:    next_rdata = {4'h0,
				port_read(dir_a, latch_a, pins_a)};
			key_port_pkg::REG_PORT_B_SETUP: next_rdata = setup_b;
			key_port_pkg::REG_PORT_B_OUT:   next_rdata = {4'h0, latch_b};
			key_port_pkg::REG_PORT_B_IN:    next_rdata = PORT_B_IS_IO
				? {4'h0, port_read(dir_b, latch_b, pins_b)} : 8'h00;
			default:                        next_rdata = 8'h00;
		endcase
	end

	// one-cycle registered ack for every access
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end
		else
		begin
			o_wb_ack <= bus_req;
			if (bus_req && !i_wb_we)
				o_wb_dat <= {24'h00_0000, next_rdata};
		end
	end
endmodule

// File: design/key_debounce.sv
// switch debounce detector for one 4-bit key port
// assumes synchronised pins and a one-cycle tap enable from the pre-divider
module key_debounce (
	input  wire logic       i_core_clk, // core clock
	input  wire logic       i_reset,    // synchronous reset
	input  wire logic       i_tick,     // gated debounce tap pulse
	input  wire logic       i_restart,  // wake condition written
	input  wire logic [3:0] i_pins,     // synchronised pin levels
	input  wire logic [3:0] i_watch,    // input-mode and selected bits
	output logic            o_detect    // one-cycle detection pulse
);
	logic [3:0] masked;
	logic [3:0] reference;
	logic [3:0] candidate;
	logic [1:0] persist;
	logic       single_change;

	assign masked = i_pins & i_watch;

	// only one pin may move while the others stay low
	assign single_change = ($countones(masked ^ reference) == 1)
		&& ($countones(masked) <= 1) && ($countones(reference) <= 1);

	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			reference <= 4'h0;
			candidate <= 4'h0;
			persist   <= 2'h0;
			o_detect  <= 1'b0;
		end
		else if (i_restart)
		begin
			reference <= masked;
			candidate <= masked;
			persist   <= 2'h0;
			o_detect  <= 1'b0;
		end
		else if (i_tick)
		begin
			o_detect <= 1'b0;
			if (!single_change)
			begin
				persist <= 2'h0;
				if (masked == reference)
					candidate <= reference;
				else
					reference <= masked;
			end
			else if (masked != candidate)
			begin
				candidate <= masked;
				persist   <= 2'h1;
			end
			else if (persist + 2'h1 >= key_port_pkg::DEBOUNCE_PERSIST)
			begin
				o_detect  <= 1'b1;
				reference <= masked;
				persist   <= 2'h0;
			end
			else
				persist <= persist + 2'h1;
		end
		else
			o_detect <= 1'b0;
	end
endmodule

// File: design/key_port_pkg.sv
// constants shared by the key port wake-up block and its submodules
// assumes a 10 MHz core clock and a classic wishbone register bus
package key_port_pkg;

	// core clock and the 32768 Hz pre-divider source it imitates
	localparam int unsigned CORE_CLK_HZ        = 10000000;
	localparam int unsigned PREDIV_IN_HZ       = 32768;
	localparam int unsigned PREDIV_TICK_CYCLES = CORE_CLK_HZ / PREDIV_IN_HZ;

	// nominal debounce intervals, one period of each tap
	localparam int unsigned DEBOUNCE_SLOW_MS = 32;
	localparam int unsigned DEBOUNCE_MID_MS  = 8;
	localparam int unsigned DEBOUNCE_FAST_MS = 2;

	// pre-divider stage numbers of the three taps
	localparam int unsigned TAP_SLOW_STAGE = 10;
	localparam int unsigned TAP_MID_STAGE  = 8;
	localparam int unsigned TAP_FAST_STAGE = 6;
	localparam int unsigned PREDIV_WIDTH   = 10;

	// cycles of one tap period, derived from the pre-divider tick
	localparam int unsigned DEBOUNCE_SLOW_CYCLES = PREDIV_TICK_CYCLES << TAP_SLOW_STAGE;
	localparam int unsigned DEBOUNCE_MID_CYCLES  = PREDIV_TICK_CYCLES << TAP_MID_STAGE;
	localparam int unsigned DEBOUNCE_FAST_CYCLES = PREDIV_TICK_CYCLES << TAP_FAST_STAGE;

	// ticks of the selected tap a change must persist
	localparam logic [1:0] DEBOUNCE_PERSIST = 2'h2;

	typedef enum logic [1:0] {
		TAP_SLOW = 2'b00,
		TAP_MID  = 2'b01,
		TAP_FAST = 2'b10
	} tap_sel_type;

	localparam tap_sel_type TAP_RESET = TAP_SLOW;

	// register byte offsets
	localparam logic [7:0] REG_CLOCK_SELECT = 8'h00;
	localparam logic [7:0] REG_WAKE_COND    = 8'h04;
	localparam logic [7:0] REG_ENABLES      = 8'h08;
	localparam logic [7:0] REG_STATUS       = 8'h0C;
	localparam logic [7:0] REG_PORT_A_SETUP = 8'h10;
	localparam logic [7:0] REG_PORT_A_OUT   = 8'h14;
	localparam logic [7:0] REG_PORT_A_IN    = 8'h18;
	localparam logic [7:0] REG_PORT_B_SETUP = 8'h1C;
	localparam logic [7:0] REG_PORT_B_OUT   = 8'h20;
	localparam logic [7:0] REG_PORT_B_IN    = 8'h24;

	// field positions
	localparam int unsigned EN_PORT_IRQ    = 0;
	localparam int unsigned EN_EXT_HALT    = 1;
	localparam int unsigned EN_EXT_IRQ     = 2;
	localparam int unsigned ST_A_WAKE      = 0;
	localparam int unsigned ST_B_WAKE      = 1;
	localparam int unsigned ST_PORT_HRQ    = 2;
	localparam int unsigned ST_EXT_HRQ     = 3;
	localparam int unsigned ST_EXT_START   = 4;

	// reset values
	localparam logic [7:0] SETUP_RESET     = 8'h00;
	localparam logic [3:0] LATCH_RESET     = 4'h0;
	localparam logic [7:0] WAKE_MASK_RESET = 8'hFF;
	localparam logic [2:0] ENABLES_RESET   = 3'h0;

endpackage

// File: design/pin_sync.sv
// three-stage synchroniser for pin inputs with agreement filter
// assumes inputs are asynchronous to i_core_clk
module pin_sync #(
	parameter int unsigned WIDTH = 4
) (
	input  wire logic             i_core_clk, // core clock
	input  wire logic             i_reset,    // synchronous reset
	input  wire logic [WIDTH-1:0] i_pin,      // raw pin levels
	output logic      [WIDTH-1:0] o_level     // accepted level
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end
		else
		begin
			stage1 <= i_pin;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// a bit moves only once the two later stages agree
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : gen_bit
			always_ff @(posedge i_core_clk)
			begin
				if (i_reset)
					o_level[g] <= 1'b0;
				else if (stage2[g] == stage3[g])
					o_level[g] <= stage3[g];
			end
		end
	endgenerate
endmodule

// File: verif/key_port_checker.sv
// port assertions for the key port block
// assumes one core clock, synchronous reset
module key_port_checker (
	input wire logic        i_core_clk,              // clock
	input wire logic        i_reset,                 // reset
	input wire logic        i_wb_cyc,                // cycle
	input wire logic        i_wb_stb,                // strobe
	input wire logic [31:0] o_wb_dat,                // read data
	input wire logic        o_wb_ack,                // ack
	input wire logic [3:0]  o_key_port_a,            // A drive
	input wire logic [3:0]  o_key_port_a_oe,         // A enable
	input wire logic [3:0]  o_key_port_b,            // B drive
	input wire logic [3:0]  o_key_port_b_oe,         // B enable
	input wire logic [3:0]  o_key_port_b_pull,       // B pull
	input wire logic        o_port_halt_release_req, // request 0
	input wire logic        o_port_irq,              // port irq
	input wire logic        o_ext_irq,               // ext irq
	input wire logic        o_wake                   // wake
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	a_ack_late: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("request not answered");
	a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack too long");
	a_rd_upper: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
		else $error("read upper bits set");
	a_b_pull_off: assert property ((o_key_port_b_oe & o_key_port_b_pull) == 4'h0)
		else $error("pull on output pin");
	a_b_drive_oe: assert property ((o_key_port_b & ~o_key_port_b_oe) == 4'h0)
		else $error("B input pin driven");
	a_a_drive_oe: assert property ((o_key_port_a & ~o_key_port_a_oe) == 4'h0)
		else $error("A input pin driven");
	a_irq_gate: assert property (o_port_irq |-> o_port_halt_release_req
		|| $past(o_port_halt_release_req))
		else $error("port irq without request");
	a_hrq_wake: assert property ($rose(o_port_halt_release_req) |-> ##[0:1] o_wake)
		else $error("request 0 without wake");
	// segment builds turn all B pins to drive right after reset
	a_dir_by_write: assert property ($changed(o_key_port_b_oe)
		|-> $past(o_wb_ack) || $past(o_wb_ack, 2) || $past(i_reset, 2))
		else $error("direction changed unasked");
	a_reset_quiet: assert property ($fell(i_reset) |-> !o_wake && !o_wb_ack
		&& o_key_port_a_oe == 4'h0 && o_key_port_b_oe == 4'h0)
		else $error("outputs active after reset");

	c_port_irq: cover property (o_port_irq);
	c_ext_wake: cover property (o_ext_irq && o_wake);
	c_hrq: cover property ($rose(o_port_halt_release_req));
endmodule

bind debounced_key_port_wakeup key_port_checker chk (.*);

// File: verif/key_switches.sv
// switch contacts on both key ports, B in the upper nibble
// assumes the block's drive, enable and pull-low per pin
module key_switches (
	input  wire logic       i_clk,  // clock
	input  wire logic       i_bnc,  // chatter on
	input  wire logic [7:0] i_sw,   // closed
	input  wire logic [7:0] i_drv,  // drive
	input  wire logic [7:0] i_oe,   // enable
	input  wire logic [7:0] i_pull, // pull-low
	output logic      [7:0] o_pin   // level
);
	logic [7:0] last = 8'h00;
	logic [7:0] chg  = 8'h00;
	logic [3:0] cnt  = 4'h0;
	logic       tog  = 1'b0;
	logic [7:0] sw;
	always @(posedge i_clk)
	begin
		tog <= ~tog;
		last <= i_sw;
		if (i_sw != last)
		begin
			chg <= i_sw ^ last;
			cnt <= i_bnc ? 4'h8 : 4'h0;
		end
		else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
	end
	// chatter only on contacts that just moved
	assign sw = i_sw ^ (cnt[0] ? chg : 8'h00);
	// open, unpulled pins float: shown toggling
	always_comb
		for (int k = 0; k < 8; k++)
			o_pin[k] = i_oe[k] ? i_drv[k] : sw[k] | (!i_pull[k] & tog);
endmodule

// File: verif/tb.sv
// self-checking bench for the key port block
// assumes the switch model and a pull-low wake pin
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TICK = 2;
	typedef struct packed {
		logic [7:0] a;
		logic [3:0] lat;
		logic [7:0] set;
		logic [3:0] sw;
		logic [3:0] in;
		logic [3:0] oe;
		logic [3:0] pl;
		logic [3:0] dr;
	} row_type;
	row_type rows[5] = '{
		'{8'h1C, 4'hA, 8'hF0, 4'h5, 4'h5, 4'h0, 4'hF, 4'h0},
		'{8'h1C, 4'hA, 8'hF3, 4'h4, 4'h6, 4'h3, 4'hC, 4'h2},
		'{8'h1C, 4'h5, 8'hFF, 4'hF, 4'h5, 4'hF, 4'h0, 4'h5},
		'{8'h10, 4'h3, 8'hF6, 4'h8, 4'hA, 4'h6, 4'h9, 4'h2},
		'{8'h10, 4'hC, 8'hF0, 4'h0, 4'h0, 4'h0, 4'hF, 4'h0}};
	int per[3] = '{TICK << key_port_pkg::TAP_SLOW_STAGE,
		TICK << key_port_pkg::TAP_MID_STAGE, TICK << key_port_pkg::TAP_FAST_STAGE};
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic        bnc = 1'b1;
	logic        ext = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [7:0]  sw = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] dat, rdat;
	logic        ack, hrq, pirq, eirq, wake, b;
	wire logic [7:0] drv, oe, pull, pin;
	row_type     r;
	int          error_cnt = 0;
	int          total_checks = 0;
	int          n;
	logic [3:0]  seg = 4'h0;
	wire logic [3:0] seg_drv, seg_oe;

	always #50 clk = ~clk;

	debounced_key_port_wakeup #(.PREDIV_TICK_CYCLES(TICK)) uut (
		.i_core_clk(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(dat), .o_wb_ack(ack),
		.i_key_port_a(pin[3:0]), .o_key_port_a(drv[3:0]), .o_key_port_a_oe(oe[3:0]),
		.o_key_port_a_pull(pull[3:0]), .i_key_port_b(pin[7:4]), .o_key_port_b(drv[7:4]),
		.i_shared_segment_output(4'h0), .o_key_port_b_oe(oe[7:4]),
		.o_key_port_b_pull(pull[7:4]), .i_ext_pin(ext), .o_port_halt_release_req(hrq),
		.o_port_irq(pirq), .o_ext_irq(eirq), .o_wake(wake));
	key_switches sws (.i_clk(clk), .i_bnc(bnc), .i_sw(sw), .i_drv(drv), .i_oe(oe),
		.i_pull(pull), .o_pin(pin));
	// segment build of port B, bus idle
	debounced_key_port_wakeup #(.PORT_B_IS_IO(1'b0), .PREDIV_TICK_CYCLES(TICK)) uut_seg (
		.i_core_clk(clk), .i_reset(rst), .i_wb_cyc(1'b0), .i_wb_stb(1'b0), .i_wb_we(1'b0),
		.i_wb_adr(8'h00), .i_wb_sel(4'h0), .i_wb_dat(32'h0), .o_wb_dat(), .o_wb_ack(),
		.i_key_port_a(4'h0), .o_key_port_a(), .o_key_port_a_oe(), .o_key_port_a_pull(),
		.i_key_port_b(4'h0), .i_shared_segment_output(seg), .o_key_port_b(seg_drv),
		.o_key_port_b_oe(seg_oe), .o_key_port_b_pull(), .i_ext_pin(1'b0),
		.o_port_halt_release_req(), .o_port_irq(), .o_ext_irq(), .o_wake());

	task chk(input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		rdat = dat;
		cyc <= 1'b0;
		we <= 1'b0;
	endtask

	task hold(output int c);
		c = 0;
		while (hrq !== 1'b1 && c < 6000)
		begin
			@(posedge clk);
			c++;
		end
	endtask

	task tick(input int c);
		repeat (c) @(posedge clk);
	endtask

	task finish_test;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		tick(20);
		rst <= 1'b0;
		foreach (rows[k])
		begin
			r = rows[k];
			b = r.a == 8'h1C;
			wb(1'b1, r.a + 8'h04, {28'h0, r.lat});
			wb(1'b1, r.a, {24'h0, r.set});
			sw <= b ? {r.sw, 4'h0} : {4'h0, r.sw};
			tick(16);
			wb(1'b0, r.a + 8'h08, 32'h0);
			chk({rdat[3:0], b ? drv[7:4] : drv[3:0]}, {r.in, r.dr});
			chk(b ? {oe[7:4], pull[7:4]} : {oe[3:0], pull[3:0]}, {r.oe, r.pl});
		end
		wb(1'b1, 8'h1C, 32'hF0);
		// slow default first, then mid, then fast
		for (int i = 0; i < 3; i++)
		begin
			if (i > 0)
				wb(1'b1, 8'h00, i);
			tick(40);
			if (i > 0)
				chk(8'(hrq), 8'h01);
			wb(1'b1, 8'h04, 32'hFF);
			tick(2);
			chk(8'(hrq), 8'h00);
			// restart takes the present level as reference, so move after it
			sw[0] <= ~sw[0];
			hold(n);
			chk(8'(n >= per[i] && n <= 2 * per[i] + 20), 8'h01);
		end
		wb(1'b1, 8'h20, 32'h2);
		wb(1'b1, 8'h1C, 32'hF2);
		wb(1'b1, 8'h04, 32'hFF);
		tick(400);
		chk(8'(hrq), 8'h00);
		sw[4] <= 1'b1;
		hold(n);
		chk(8'(n <= 276), 8'h01);
		wb(1'b0, 8'h24, 32'h0);
		chk(rdat[7:0], 8'h03);
		wb(1'b0, 8'h0C, 32'h0);
		chk(rdat[7:0], 8'h06);
		wb(1'b1, 8'h08, 32'h1);
		tick(3);
		chk(8'(pirq), 8'h01);
		wb(1'b1, 8'h08, 32'h0);
		tick(3);
		chk(8'(pirq), 8'h00);
		wb(1'b1, 8'h04, 32'hFF);
		sw[6] <= 1'b1;
		tick(400);
		chk(8'(hrq), 8'h00);
		ext <= 1'b1;
		tick(8);
		wb(1'b0, 8'h0C, 32'h0);
		chk(rdat[7:0], 8'h08);
		chk({3'h0, eirq, 3'h0, wake}, 8'h00);
		wb(1'b1, 8'h0C, 32'h18);
		wb(1'b1, 8'h08, 32'h2);
		ext <= 1'b0;
		tick(8);
		chk(8'(wake), 8'h00);
		ext <= 1'b1;
		tick(8);
		chk({3'h0, eirq, 3'h0, wake}, 8'h01);
		wb(1'b1, 8'h08, 32'h6);
		tick(3);
		chk(8'(eirq), 8'h01);
		wb(1'b0, 8'h0C, 32'h0);
		chk(rdat[7:0], 8'h18);
		wb(1'b1, 8'h3C, 32'hFF);
		wb(1'b0, 8'h3C, 32'h0);
		chk(rdat[7:0], 8'h00);
		seg <= 4'hA;
		tick(3);
		chk({seg_drv, seg_oe}, 8'hAF);
		rst <= 1'b1;
		tick(2);
		rst <= 1'b0;
		tick(2);
		chk(oe | pull, 8'h00);
		chk(8'(hrq), 8'h00);
		finish_test;
	end

	initial
	begin
		tick(30000);
		error_cnt++;
		finish_test;
	end
endmodule
